// ---- design/dciv_pkg.sv ----
// Purpose: Constants for the chained vectored interrupt controller
// Assumes: Avalon-MM slave, byte addresses, 32-bit words
// Notes: Slot tables sit in two 32-word windows
package dciv_pkg;
  localparam int NCH = 32;
  localparam int UNIT = 16;
  localparam int AW = 9;
  // Register byte offsets
  localparam logic [8:0] ENABLE_OFS = 9'h000;
  localparam logic [8:0] FAST_SEL_OFS = 9'h004;
  localparam logic [8:0] FORCE_OFS = 9'h008;
  localparam logic [8:0] RAW_OFS = 9'h00c;
  localparam logic [8:0] VREQ_OFS = 9'h010;
  localparam logic [8:0] VECT_ADDR_OFS = 9'h014;
  localparam logic [8:0] SOURCE_ID_OFS = 9'h018;
  localparam logic [8:0] DEF_VECT_OFS = 9'h01c;
  localparam logic [8:0] INSTR_OFS = 9'h020;
  localparam logic [8:0] INT_STAT_OFS = 9'h024;
  localparam logic [8:0] INT_MASK_OFS = 9'h028;
  localparam logic [1:0] SLOT_CTRL_WIN = 2'h2;
  localparam logic [1:0] SLOT_VECT_WIN = 2'h3;
  // Field positions
  localparam int SLOT_ON_BIT = 4;
  localparam int SRC_VALID_BIT = 5;
  localparam int WAKE_CH = 25;
  localparam int EV_FAST = 0;
  localparam int EV_IRQ = 1;
  localparam int EV_WAKE = 2;
  // Values after reset
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] FAST_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] FORCE_RST = 32'h0000_0000;
  localparam logic [31:0] DEF_VECT_RST = 32'h0000_0000;
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;
  localparam logic [2:0] INT_RST = 3'h0;
  localparam logic [4:0] SLOT_CTRL_RST = 5'h00;
  localparam logic [31:0] SLOT_VECT_RST = 32'h0000_0000;
endpackage

// ---- design/dciv_ctrl.sv ----
// Purpose: Two chained 16-slot vectored units plus a fast request path
// Assumes: Sources are asynchronous levels; bus runs on sys_clk_in
// Notes: One wait state per bus access; outputs are registered
// Function
// [RULE_01] Accept 32 prioritized request channels and drive a fast and a vectored request.
// [RULE_02] Build the controller from a primary and a secondary 16-slot unit chained together.
// [RULE_03] The fast request is non-vectored and any of the 32 requests can be routed to it.
// [RULE_04] Firmware should normally route only one source to the fast request.
// [RULE_05] The vectored request is the OR of all requests routed to vectored channels.
// [RULE_06] Slot priority is fixed, slot 0 highest and slot 31 lowest.
// [RULE_07] Firmware maps sources onto slots inside each unit, giving levels 0 to 16; the code has 16 slots per unit, levels 0 to 15.
// [RULE_08] Any active primary request beats every secondary request.
// [RULE_09] Hardware resolves the winner; a read returns its source and vector address.
// [RULE_10] A dedicated cache entry holds the instruction that reads the vector.
// [RULE_11] Five channels come from the wake-up unit and 27 from internal sources.
// [RULE_12] Firmware can force a request on any channel.
// [RULE_13] Channel 25 is the OR of all 32 wake-up inputs.
// [RULE_14] Wake-up inputs are 30 pin interrupts, the clock alarm and bus resume.
// [RULE_15] The vector is the primary one when the primary has a hit, else the secondary one.
// [RULE_16] Each output stays high while a qualifying request stays active.
`timescale 1ns/100ps
`default_nettype none
module dciv_ctrl (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Request sources
  input wire logic [26:0] int_src_in,
  input wire logic [3:0] wake_req_in,
  input wire logic [29:0] pin_wake_in,
  input wire logic rtc_wake_in,
  input wire logic resume_wake_in,
  // Processor side
  output logic fast_irq_out,
  output logic vect_irq_out,
  output logic [31:0] vector_addr_out,
  output logic [31:0] branch_target_store_out,
  // Avalon-MM slave
  input wire logic [8:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Block interrupt
  output logic ctrl_irq_out
);
  logic [62:0] sync1;
  logic [62:0] sync2;
  logic [31:0] wake_all;
  logic [31:0] raw;
  logic [31:0] req;
  logic [31:0] vreq;
  logic [31:0] enable;
  logic [31:0] fast_sel;
  logic [31:0] force_req;
  logic [31:0] def_vect;
  logic [31:0] instr_word;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [4:0] slot_ctrl [32];
  logic [31:0] slot_vect [32];
  logic [31:0] slot_hit;
  logic [3:0] pwin;
  logic [3:0] swin;
  logic [31:0] next_vect;
  logic [5:0] next_src;
  logic [5:0] source_id;
  logic [2:0] events;
  logic fast_d;
  logic irq_d;
  logic wake_d;
  logic acc;
  logic wr_ok;
  logic [6:0] widx;

  // Two-flop synchronisers on every source pin
  always_ff @(posedge sys_clk_in)
  begin
    sync1 <= {resume_wake_in, rtc_wake_in, pin_wake_in, wake_req_in, int_src_in};
    sync2 <= sync1;
  end

  // Channel assembly: wake-up unit on 25..29, internal sources elsewhere
  assign wake_all = sync2[62:31]; // [RULE_14]
  always_comb
  begin
    raw = {sync2[26:25], sync2[30:27], |wake_all, sync2[24:0]}; // [RULE_11] [RULE_13]
  end

  // Registered request vector, forced bits added
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      req <= 32'h0000_0000;
    else
      req <= raw | force_req; // [RULE_12]
  end

  assign vreq = req & enable & ~fast_sel;

  // Per-slot hit within its own unit
  genvar k;
  generate
    for (k = 0; k < dciv_pkg::NCH; k++)
    begin : g_slot
      localparam logic [4:0] BASE = 5'((k / dciv_pkg::UNIT) * dciv_pkg::UNIT);
      assign slot_hit[k] = slot_ctrl[k][dciv_pkg::SLOT_ON_BIT]
        & vreq[BASE + {1'b0, slot_ctrl[k][3:0]}]; // [RULE_07] [RULE_02]
    end
  endgenerate

  // Fixed priority inside each unit, lowest slot wins
  always_comb
  begin
    pwin = 4'h0;
    swin = 4'h0;
    for (int i = dciv_pkg::UNIT - 1; i >= 0; i--)
    begin
      if (slot_hit[i])
        pwin = 4'(i); // [RULE_06]
      if (slot_hit[i + dciv_pkg::UNIT])
        swin = 4'(i);
    end
  end

  // Chain: primary first, then secondary, then default
  always_comb
  begin
    next_vect = def_vect;
    next_src = 6'h00;
    for (int i = dciv_pkg::NCH - 1; i >= 0; i--)
      if (vreq[i])
        next_src = {1'b1, 5'(i)};
    if (|slot_hit[15:0])
    begin
      next_vect = slot_vect[{1'b0, pwin}]; // [RULE_08] [RULE_15]
      next_src = {1'b1, 1'b0, slot_ctrl[{1'b0, pwin}][3:0]};
    end
    else if (|slot_hit[31:16])
    begin
      next_vect = slot_vect[{1'b1, swin}]; // [RULE_15]
      next_src = {1'b1, 1'b1, slot_ctrl[{1'b1, swin}][3:0]};
    end
  end

  // Outputs to the core, held while requests stay active
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      fast_irq_out <= 1'b0;
      vect_irq_out <= 1'b0;
      vector_addr_out <= dciv_pkg::DEF_VECT_RST;
      source_id <= 6'h00;
    end
    else
    begin
      fast_irq_out <= |(req & enable & fast_sel); // [RULE_03] [RULE_16] [RULE_01]
      vect_irq_out <= |vreq; // [RULE_05] [RULE_16]
      vector_addr_out <= next_vect; // [RULE_09]
      source_id <= next_src; // [RULE_09]
    end
  end

  // Dedicated cache entry carrying the vector-read instruction
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      branch_target_store_out <= dciv_pkg::INSTR_RST;
    else
      branch_target_store_out <= instr_word; // [RULE_10]
  end

  // Bus handshake: one wait state, write lands when waitrequest is low
  assign acc = avs_read_in | avs_write_in;
  assign wr_ok = avs_write_in & ~avs_waitrequest_out;
  assign widx = avs_address_in[8:2];
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= ~(acc & avs_waitrequest_out);
  end

  // Control registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      enable <= dciv_pkg::ENABLE_RST;
      fast_sel <= dciv_pkg::FAST_SEL_RST;
      force_req <= dciv_pkg::FORCE_RST;
      def_vect <= dciv_pkg::DEF_VECT_RST;
      instr_word <= dciv_pkg::INSTR_RST;
      int_mask <= dciv_pkg::INT_RST;
    end
    else if (wr_ok)
    begin
      case (avs_address_in)
        dciv_pkg::ENABLE_OFS: enable <= avs_writedata_in;
        dciv_pkg::FAST_SEL_OFS: fast_sel <= avs_writedata_in; // [RULE_03]
        dciv_pkg::FORCE_OFS: force_req <= avs_writedata_in; // [RULE_12]
        dciv_pkg::DEF_VECT_OFS: def_vect <= avs_writedata_in;
        dciv_pkg::INSTR_OFS: instr_word <= avs_writedata_in; // [RULE_10]
        dciv_pkg::INT_MASK_OFS: int_mask <= avs_writedata_in[2:0];
        default: ;
      endcase
    end
  end

  // Slot tables
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < dciv_pkg::NCH; i++)
      begin
        slot_ctrl[i] <= dciv_pkg::SLOT_CTRL_RST;
        slot_vect[i] <= dciv_pkg::SLOT_VECT_RST;
      end
    end
    else if (wr_ok && widx[6:5] == dciv_pkg::SLOT_CTRL_WIN)
      slot_ctrl[widx[4:0]] <= avs_writedata_in[4:0]; // [RULE_07]
    else if (wr_ok && widx[6:5] == dciv_pkg::SLOT_VECT_WIN)
      slot_vect[widx[4:0]] <= avs_writedata_in;
  end

  // Sticky events, set wins over write-one-to-clear
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      fast_d <= 1'b0;
      irq_d <= 1'b0;
      wake_d <= 1'b0;
    end
    else
    begin
      fast_d <= fast_irq_out;
      irq_d <= vect_irq_out;
      wake_d <= req[dciv_pkg::WAKE_CH];
    end
  end
  assign events = {req[dciv_pkg::WAKE_CH] & ~wake_d, vect_irq_out & ~irq_d, fast_irq_out & ~fast_d};
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      int_status <= dciv_pkg::INT_RST;
    else if (wr_ok && avs_address_in == dciv_pkg::INT_STAT_OFS)
      int_status <= (int_status & ~avs_writedata_in[2:0]) | events;
    else
      int_status <= int_status | events;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      ctrl_irq_out <= 1'b0;
    else
      ctrl_irq_out <= |(int_status & int_mask);
  end

  // Read data, captured on the wait cycle; unmapped reads give zero
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && avs_waitrequest_out)
    begin
      if (widx[6:5] == dciv_pkg::SLOT_CTRL_WIN)
        avs_readdata_out <= {27'h0, slot_ctrl[widx[4:0]]};
      else if (widx[6:5] == dciv_pkg::SLOT_VECT_WIN)
        avs_readdata_out <= slot_vect[widx[4:0]];
      else
        case (avs_address_in)
          dciv_pkg::ENABLE_OFS: avs_readdata_out <= enable;
          dciv_pkg::FAST_SEL_OFS: avs_readdata_out <= fast_sel;
          dciv_pkg::FORCE_OFS: avs_readdata_out <= force_req;
          dciv_pkg::RAW_OFS: avs_readdata_out <= req;
          dciv_pkg::VREQ_OFS: avs_readdata_out <= vreq;
          dciv_pkg::VECT_ADDR_OFS: avs_readdata_out <= vector_addr_out; // [RULE_09]
          dciv_pkg::SOURCE_ID_OFS: avs_readdata_out <= {26'h0, source_id}; // [RULE_09]
          dciv_pkg::DEF_VECT_OFS: avs_readdata_out <= def_vect;
          dciv_pkg::INSTR_OFS: avs_readdata_out <= instr_word;
          dciv_pkg::INT_STAT_OFS: avs_readdata_out <= {29'h0, int_status};
          dciv_pkg::INT_MASK_OFS: avs_readdata_out <= {29'h0, int_mask};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_fast_route: assert property (|(req & enable & fast_sel) |=> fast_irq_out) // [RULE_03]
    else $error("fast request not raised");
  a_vect_or: assert property (##1 vect_irq_out == $past(|vreq)) // [RULE_05]
    else $error("vectored request is not the OR");
  a_hold_level: assert property (vect_irq_out && |vreq |=> vect_irq_out) // [RULE_16]
    else $error("vectored request dropped early");
  a_primary_wins: assert property (|slot_hit[15:0] |=> source_id[4] == 1'b0) // [RULE_08]
    else $error("secondary beat primary");
  a_slot0_top: assert property (slot_hit[0] |=> vector_addr_out == $past(slot_vect[0])) // [RULE_06]
    else $error("slot 0 lost priority");
  a_second_vect: assert property (!(|slot_hit[15:0]) && slot_hit[16]
    |=> vector_addr_out == $past(slot_vect[16])) // [RULE_15]
    else $error("secondary vector wrong");
  a_wake_or: assert property (|wake_all |=> req[25]) // [RULE_13]
    else $error("wake-up OR not seen");
  a_force_req: assert property (##1 (req & $past(force_req)) == $past(force_req)) // [RULE_12]
    else $error("forced request missing");
  a_bus_wait: assert property (acc && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_sticky_set: assert property (|events |=> (int_status & $past(events)) == $past(events))
    else $error("event lost");
  c_fast: cover property (fast_irq_out && vect_irq_out);
  c_primary: cover property (|slot_hit[15:0] && |slot_hit[31:16]);
  c_secondary: cover property (!(|slot_hit[15:0]) && |slot_hit[31:16]);
  c_wake: cover property (req[25] && ctrl_irq_out);
endmodule
`default_nettype wire

// ---- verif/dciv_src_model.sv ----
// Purpose: Request sources facing the interrupt controller
// Assumes: Levels are held by the bench per channel
// Notes: Channel 25 comes only from the wake inputs
`timescale 1ns/100ps
`default_nettype none
module dciv_src_model (
  // Channel and wake levels from the bench
  input wire logic [31:0] chan_in,
  input wire logic [31:0] wake_in,
  // Controller source pins
  output logic [26:0] int_src_out,
  output logic [3:0] wake_req_out,
  output logic [29:0] pin_wake_out,
  output logic rtc_wake_out,
  output logic resume_wake_out
);
  // Internal sources fill every channel but 25..29
  assign int_src_out = {chan_in[31:30], chan_in[24:0]};
  // Wake unit drives channels 26..29
  assign wake_req_out = chan_in[29:26];
  // Thirty pins, clock alarm and bus resume
  assign pin_wake_out = wake_in[29:0];
  assign rtc_wake_out = wake_in[30];
  assign resume_wake_out = wake_in[31];
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the chained interrupt controller
// Assumes: One wait state per bus access, request outputs settle in 4 edges, ctrl_irq_out in 6
// Notes: Model holds slot tables and predicts winner and vector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst, rd, wr, fast, vect, cirq, wait_r, rtc, res, m_vst, m_vprev, m_mask1;
  logic [31:0] chan, wake, vaddr, bts, rdata, wdata, q, seed, m_en, m_fast, m_force, m_def;
  logic [26:0] src;
  logic [3:0] wreq;
  logic [29:0] pins;
  logic [8:0] addr;
  logic [4:0] m_sc [32];
  logic [31:0] m_sv [32];
  int errors, comparisons, k;
  dciv_src_model u_dciv_src_model (.chan_in(chan), .wake_in(wake), .int_src_out(src),
    .wake_req_out(wreq), .pin_wake_out(pins), .rtc_wake_out(rtc), .resume_wake_out(res));
  dciv_ctrl u_dciv_ctrl (.sys_clk_in(clk), .rst_in(rst), .int_src_in(src),
    .wake_req_in(wreq), .pin_wake_in(pins), .rtc_wake_in(rtc), .resume_wake_in(res),
    .fast_irq_out(fast), .vect_irq_out(vect), .vector_addr_out(vaddr),
    .branch_target_store_out(bts), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_r), .ctrl_irq_out(cirq));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task results;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Avalon master: hold until waitrequest is sampled low
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    while (wait_r !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        results();
      end
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task slot(input int s, input logic [3:0] src_sel);
    seed = lfsr(seed);
    m_sc[s] = {1'b1, src_sel};
    m_sv[s] = seed;
    bus(1'b1, 9'(9'h100 + 4 * s), {27'h0, 1'b1, src_sel});
    bus(1'b1, 9'(9'h180 + 4 * s), seed);
    bus(1'b0, 9'(9'h180 + 4 * s), 32'h0);
    cmp("slot_vect", m_sv[s], q);
  endtask
  // Predict outputs from the model and compare them all
  task check_all;
    logic [31:0] act, vq, va;
    logic [5:0] sid;
    int c;
    act = (chan | m_force | ({31'h0, |wake} << 25)) & m_en;
    vq = act & ~m_fast;
    va = m_def;
    sid = 6'h00;
    for (int s = 31; s >= 0; s--)
      if (vq[s])
        sid = {1'b1, 5'(s)};
    for (int s = 31; s >= 0; s--)
    begin
      c = (s < 16 ? 0 : 16) + int'(m_sc[s][3:0]);
      if (m_sc[s][4] && vq[c])
      begin
        va = m_sv[s];
        sid = {1'b1, 5'(c)};
      end
    end
    m_vst = m_vst | (|vq & !m_vprev);
    m_vprev = |vq;
    cmp("fast_irq", {31'h0, |(act & m_fast)}, {31'h0, fast});
    cmp("vect_irq", {31'h0, |vq}, {31'h0, vect});
    cmp("vector_addr", va, vaddr);
    bus(1'b0, dciv_pkg::VECT_ADDR_OFS, 32'h0);
    cmp("vect_addr_reg", va, q);
    bus(1'b0, dciv_pkg::SOURCE_ID_OFS, 32'h0);
    cmp("source_id", {26'h0, sid}, q);
    bus(1'b0, dciv_pkg::VREQ_OFS, 32'h0);
    cmp("vreq_reg", vq, q);
    bus(1'b0, dciv_pkg::RAW_OFS, 32'h0);
    cmp("raw_reg", chan | m_force | ({31'h0, |wake} << 25), q);
    cmp("ctrl_irq", {31'h0, m_vst & m_mask1}, {31'h0, cirq});
  endtask
  task set_src(input logic [31:0] c, input logic [31:0] w);
    chan <= c;
    wake <= w;
    repeat (6) @(posedge clk);
    check_all();
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {rd, wr, addr, wdata, chan, wake} = 107'h0;
    {errors, comparisons, m_vst, m_vprev, m_mask1} = 67'h0;
    {m_en, m_fast, m_force, m_def} = 128'h0;
    seed = 32'hbdda4208;
    for (k = 0; k < 32; k++)
      {m_sc[k], m_sv[k]} = 37'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, then an unmapped hole
    for (k = 0; k <= 44; k += 4)
    begin
      bus(1'b0, 9'(k), 32'h0);
      cmp("reset_reg", 32'h0, q);
    end
    bus(1'b1, 9'h0fc, 32'hffffffff);
    bus(1'b0, 9'h0fc, 32'h0);
    cmp("unmapped", 32'h0, q);
    seed = lfsr(seed);
    bus(1'b1, dciv_pkg::INSTR_OFS, seed);
    @(posedge clk);
    cmp("cache_word", seed, bts);
    m_en = 32'hffffffff;
    bus(1'b1, dciv_pkg::ENABLE_OFS, m_en);
    m_def = lfsr(seed);
    bus(1'b1, dciv_pkg::DEF_VECT_OFS, m_def);
    m_mask1 = 1'b1;
    bus(1'b1, dciv_pkg::INT_MASK_OFS, 32'h2);
    slot(0, 4'h5);
    slot(1, 4'h3);
    slot(16, 4'h0);
    set_src(32'h8, 32'h0);
    set_src(32'h28, 32'h0);
    set_src(32'h10008, 32'h0);
    set_src(32'h10000, 32'h0);
    set_src(32'h200, 32'h0);
    set_src(32'h0, 32'h0);
    // Sticky status: mask off, on, then clear
    bus(1'b0, dciv_pkg::INT_STAT_OFS, 32'h0);
    cmp("int_stat", {30'h0, m_vst, 1'b0}, q & 32'h2);
    bus(1'b1, dciv_pkg::INT_MASK_OFS, 32'h0);
    // The level follows the mask one edge after the write lands
    @(posedge clk);
    cmp("masked_irq", 32'h0, {31'h0, cirq});
    bus(1'b1, dciv_pkg::INT_MASK_OFS, 32'h2);
    @(posedge clk);
    cmp("unmasked_irq", 32'h1, {31'h0, cirq});
    bus(1'b1, dciv_pkg::INT_STAT_OFS, 32'h2);
    m_vst = 1'b0;
    set_src(32'h0, 32'h0);
    // Fast path beside a vectored request
    m_fast = 32'h80;
    bus(1'b1, dciv_pkg::FAST_SEL_OFS, m_fast);
    set_src(32'h80, 32'h0);
    set_src(32'h88, 32'h0);
    // Forced request with no source active
    m_force = 32'h100000;
    bus(1'b1, dciv_pkg::FORCE_OFS, m_force);
    set_src(32'h0, 32'h0);
    m_force = 32'h0;
    bus(1'b1, dciv_pkg::FORCE_OFS, m_force);
    // Any wake input lands on channel 25
    for (k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      set_src(32'h0, 32'h1 << seed[4:0]);
    end
    set_src(32'h0, 32'hc0000000);
    // Disabled channel stays silent
    m_en = 32'hffffffef;
    bus(1'b1, dciv_pkg::ENABLE_OFS, m_en);
    set_src(32'h10, 32'h0);
    results();
  end
endmodule
`default_nettype wire
